// [include/pscw_map.svh]
// constants for the pci-side control and wake link
// assumes a 250 MHz clock; included by both ends and the testbench
`ifndef PSCW_MAP_SVH
`define PSCW_MAP_SVH
`define PSCW_CLK_PERIOD_PS 4000
`define PSCW_RESET_HOLD_US 100
`define PSCW_RESET_HOLD_CYC ((`PSCW_RESET_HOLD_US * 1000000 + `PSCW_CLK_PERIOD_PS - 1) / `PSCW_CLK_PERIOD_PS)
`define PSCW_PWR_WAKE_EN_BIT 18
`define PSCW_PWR_PROTO_SEL_BIT 17
`define PSCW_AD_WIDTH 32
`define PSCW_PULSE_CYC 8
`endif

// [include/pscw_pkg.sv]
// types used by the device end of the pci-side control link
// assumes nothing beyond the map header
package pscw_pkg;
    typedef enum logic [1:0] {
        PSCW_IDLE,
        PSCW_REQ,
        PSCW_ADDR,
        PSCW_DATA
    } pscw_mst_state_t;
    typedef enum logic {
        PSCW_PROTO_ALT,
        PSCW_PROTO_FIRST
    } pscw_proto_t;
endpackage

// [include/pscw_if.sv]
// link between the network device end and the host/arbiter end
// assumes one shared clock; the testbench resolves the shared bus level, the host decodes open-drain enables directly
`timescale 1ns/1ps
interface pscw_if;
    logic inta_n_o;
    logic inta_oe;
    logic pme_n_o;
    logic pme_oe;
    logic req_n;
    logic gnt_n;
    logic [31:0] ad_dev_o;
    logic ad_dev_oe;
    logic [31:0] ad_host_o;
    logic ad_host_oe;
    logic [31:0] ad_i;
    logic rst_n;
    modport device (
        output inta_n_o, inta_oe, pme_n_o, pme_oe, req_n, ad_dev_o, ad_dev_oe,
        input gnt_n, ad_i, rst_n
    );
    modport host (
        input inta_n_o, inta_oe, pme_n_o, pme_oe, req_n, ad_dev_o, ad_dev_oe, ad_i,
        output gnt_n, ad_host_o, ad_host_oe, rst_n
    );
endinterface

// [verilog/pscw_device.sv]
// device end: interrupt, bus request/grant master, shared address/data bus, wake event
// assumes the link reset from the host is synchronous to CLK_I and held long enough
`timescale 1ns/1ps
`include "pscw_map.svh"

// What this block does
// - interrupt driven while any enabled event set
// - host holds reset at least 100 us
// - reset floats the open-drain pins and the bus; request is driven high
// - all bus signals on rising clock edge
// - system clock within 20 to 33 MHz; the map header assumes 250 MHz
// - request asserted when master access needed
// - grant from arbiter permits master transfer
// - wake event output driven low on event
// - wake enable bit 18 enters wake mode
// - magic packet in wake mode raises event
// - bit 17 selects first or alternative protocol
// - address and data share one 32-bit bus
module pscw_device #(
    parameter int EVENTS = 8
) (
    input wire logic CLK_I,
    input wire logic [EVENTS-1:0] EVENT_SET_I,
    input wire logic [EVENTS-1:0] EVENT_CLR_I,
    input wire logic [EVENTS-1:0] EVENT_MASK_I,
    input wire logic [31:0] POWER_CONTROL_I,
    input wire logic MAGIC_PACKET_I,
    input wire logic PME_CLR_I,
    input wire logic XFER_START_I,
    input wire logic [31:0] XFER_ADDR_I,
    input wire logic [31:0] XFER_DATA_I,
    output logic XFER_BUSY_O,
    output logic XFER_DONE_O,
    output logic [EVENTS-1:0] EVENT_FLAGS_O,
    output logic WAKE_ACTIVE_O,
    pscw_if.device LINK
);
    // flag vector is kept within one bus word
    if (EVENTS < 1 || EVENTS > 32)
    begin : g_events_check
        $error("EVENTS must be 1 to 32");
    end

    logic [EVENTS-1:0] event_flags;
    logic [EVENTS-1:0] next_event_flags;
    logic inta_on;
    logic pme_on;
    logic pme_pulse_mode;
    logic [3:0] pme_cnt;
    logic req_on;
    logic ad_oe;
    logic [31:0] ad_out;
    logic [31:0] pend_data;
    logic busy;
    logic done;
    logic wake_mode;
    logic in_reset;
    logic start_take;
    logic grant_take;
    logic data_phase;
    pscw_pkg::pscw_mst_state_t state;

    assign in_reset = ~LINK.rst_n;
    // set wins over clear so a same-cycle event is kept
    assign next_event_flags = (event_flags & ~EVENT_CLR_I) | EVENT_SET_I;
    assign wake_mode = POWER_CONTROL_I[`PSCW_PWR_WAKE_EN_BIT];

    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
            event_flags <= '0;
        else
            event_flags <= next_event_flags;
    end

    // registered so the pin never glitches on a decode hazard
    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
            inta_on <= 1'b0;
        else
            inta_on <= |(next_event_flags & EVENT_MASK_I);
    end

    // first protocol: level held until software clears; alternative: fixed pulse
    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
        begin
            pme_on <= 1'b0;
            pme_pulse_mode <= 1'b0;
            pme_cnt <= 4'h0;
        end
        // a new packet mid-pulse restarts the count
        else if (wake_mode && MAGIC_PACKET_I)
        begin
            pme_on <= 1'b1;
            pme_pulse_mode <= ~POWER_CONTROL_I[`PSCW_PWR_PROTO_SEL_BIT];
            pme_cnt <= 4'(`PSCW_PULSE_CYC - 1);
        end
        else if (pme_on && pme_pulse_mode)
        begin
            if (pme_cnt == 4'h0)
                pme_on <= 1'b0;
            else
                pme_cnt <= pme_cnt - 4'h1;
        end
        else if (PME_CLR_I)
            pme_on <= 1'b0;
    end

    // a start is only taken while idle; starts during a tenure are dropped
    assign start_take = (state == pscw_pkg::PSCW_IDLE) && XFER_START_I;
    assign grant_take = (state == pscw_pkg::PSCW_REQ) && !LINK.gnt_n;
    assign data_phase = (state == pscw_pkg::PSCW_DATA);

    // one transfer per tenure: address phase then a single data phase
    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
            state <= pscw_pkg::PSCW_IDLE;
        else
        begin
            unique case (state)
                pscw_pkg::PSCW_IDLE:
                begin
                    if (start_take)
                        state <= pscw_pkg::PSCW_REQ;
                end
                pscw_pkg::PSCW_REQ:
                begin
                    if (grant_take)
                        state <= pscw_pkg::PSCW_ADDR;
                end
                pscw_pkg::PSCW_ADDR:
                    state <= pscw_pkg::PSCW_DATA;
                pscw_pkg::PSCW_DATA:
                    state <= pscw_pkg::PSCW_IDLE;
            endcase
        end
    end

    // request held over the whole tenure so the arbiter cannot take the bus mid-word
    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
        begin
            req_on <= 1'b0;
            busy <= 1'b0;
        end
        else if (start_take)
        begin
            req_on <= 1'b1;
            busy <= 1'b1;
        end
        else if (data_phase)
        begin
            req_on <= 1'b0;
            busy <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
            ad_oe <= 1'b0;
        else if (grant_take)
            ad_oe <= 1'b1;
        else if (data_phase)
            ad_oe <= 1'b0;
    end

    // only one address/data pair is latched; a burst would need a queue here
    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
        begin
            ad_out <= 32'h0;
            pend_data <= 32'h0;
        end
        else if (start_take)
        begin
            ad_out <= XFER_ADDR_I;
            pend_data <= XFER_DATA_I;
        end
        else if (state == pscw_pkg::PSCW_ADDR)
            ad_out <= pend_data;
    end

    // one-cycle completion strobe, the cycle the bus is released
    always_ff @(posedge CLK_I)
    begin
        if (in_reset)
            done <= 1'b0;
        else
            done <= data_phase;
    end

    // open drain: drive low only while asserted, otherwise release
    assign LINK.inta_n_o = 1'b0;
    assign LINK.inta_oe = inta_on;
    assign LINK.pme_n_o = 1'b0;
    assign LINK.pme_oe = pme_on;
    assign LINK.req_n = ~req_on;
    assign LINK.ad_dev_o = ad_out;
    assign LINK.ad_dev_oe = ad_oe;
    assign XFER_BUSY_O = busy;
    assign XFER_DONE_O = done;
    assign EVENT_FLAGS_O = event_flags;
    assign WAKE_ACTIVE_O = pme_on;
endmodule

// [verilog/pscw_host.sv]
// host end: reset generator, bus arbiter, bus sampling, interrupt and wake observers
// assumes the device end shares CLK_I
`timescale 1ns/1ps
`include "pscw_map.svh"

module pscw_host #(
    parameter int RESET_HOLD_CYC = `PSCW_RESET_HOLD_CYC
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic ARB_ENABLE_I,
    output logic LINK_READY_O,
    output logic IRQ_O,
    output logic WAKE_O,
    output logic [31:0] ADDR_O,
    output logic [31:0] DATA_O,
    output logic WORD_VALID_O,
    pscw_if.host LINK
);
    if (RESET_HOLD_CYC < 1)
    begin : g_hold_check
        $error("RESET_HOLD_CYC must be at least 1");
    end

    logic [31:0] hold_cnt;
    logic link_rst_n;
    logic gnt_on;
    logic irq;
    logic wake;
    logic [31:0] addr;
    logic [31:0] data;
    logic valid;
    logic phase;

    // reset held for the minimum time, shortened only through the parameter
    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            hold_cnt <= 32'h0;
            link_rst_n <= 1'b0;
        end
        else if (hold_cnt < 32'(RESET_HOLD_CYC))
            hold_cnt <= hold_cnt + 32'h1;
        else
            link_rst_n <= 1'b1;
    end

    // single requester: grant follows request while arbitration is enabled
    always_ff @(posedge CLK_I)
    begin
        if (!link_rst_n)
            gnt_on <= 1'b0;
        else
            gnt_on <= ARB_ENABLE_I && !LINK.req_n;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!link_rst_n)
        begin
            irq <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            irq <= LINK.inta_oe && !LINK.inta_n_o;
            wake <= LINK.pme_oe && !LINK.pme_n_o;
        end
    end

    // first driven word is the address, the next the data
    always_ff @(posedge CLK_I)
    begin
        if (!link_rst_n)
        begin
            addr <= 32'h0;
            data <= 32'h0;
            valid <= 1'b0;
            phase <= 1'b0;
        end
        else
        begin
            valid <= 1'b0;
            if (LINK.ad_dev_oe)
            begin
                if (!phase)
                    addr <= LINK.ad_i;
                else
                begin
                    data <= LINK.ad_i;
                    valid <= 1'b1;
                end
                phase <= ~phase;
            end
            else
                phase <= 1'b0;
        end
    end

    assign LINK.rst_n = link_rst_n;
    assign LINK.gnt_n = ~gnt_on;
    assign LINK.ad_host_o = 32'h0;
    assign LINK.ad_host_oe = 1'b0;
    assign LINK_READY_O = link_rst_n;
    assign IRQ_O = irq;
    assign WAKE_O = wake;
    assign ADDR_O = addr;
    assign DATA_O = data;
    assign WORD_VALID_O = valid;
endmodule

// [test/pscw_properties.sv]
// link checker: reset, grant, bus phases, open-drain levels
// assumes one clock; instanced beside the link
`timescale 1ns/1ps
module pscw_properties #(
    parameter int RESET_HOLD_CYC = 4
) (
    input wire logic CLK_I,
    input wire logic rst_n,
    input wire logic inta_n_o,
    input wire logic inta_oe,
    input wire logic pme_n_o,
    input wire logic pme_oe,
    input wire logic req_n,
    input wire logic gnt_n,
    input wire logic ad_dev_oe
);
    int low_cnt = 0;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge CLK_I)
    begin
        low_cnt <= rst_n ? 0 : low_cnt + 1;
    end
    rst_hold_a: assert property (disable iff (1'b0) $rose(rst_n) |-> low_cnt > RESET_HOLD_CYC)
        else $error("link reset too short");
    rst_float_a: assert property (disable iff (1'b0)
        !rst_n && !$past(rst_n) |-> !inta_oe && !pme_oe && !ad_dev_oe && req_n)
        else $error("pins driven in reset");
    grant_first_a: assert property ($rose(ad_dev_oe) |-> !$past(gnt_n))
        else $error("bus driven without grant");
    grant_use_a: assert property ($fell(gnt_n) |=> ad_dev_oe)
        else $error("grant not used");
    ad_two_a: assert property ($rose(ad_dev_oe) |=> ad_dev_oe ##1 !ad_dev_oe)
        else $error("address/data phases wrong");
    req_hold_a: assert property (ad_dev_oe |-> !req_n)
        else $error("request dropped while mastering");
    req_drop_a: assert property ($fell(ad_dev_oe) |-> req_n)
        else $error("request kept after transfer");
    pme_low_a: assert property (pme_oe |-> !pme_n_o)
        else $error("wake pin not low");
    irq_low_a: assert property (inta_oe |-> !inta_n_o)
        else $error("interrupt pin not low");
    cover property ($rose(ad_dev_oe));
    cover property ($rose(pme_oe));
    cover property ($rose(inta_oe));
endmodule

// [test/testbench.sv]
// self-checking bench joining device and host ends
// assumes design files, link and map header compiled first
`timescale 1ns/1ps
`include "pscw_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic CLK_I = 0;
    logic RESET_N_I = 0;
    logic arb = 1;
    logic [7:0] ev_set = 0, ev_clr = 0, ev_mask = 0, flags;
    logic [31:0] pwr = 0, x_addr = 0, x_data = 0, h_addr, h_data;
    logic magic = 0, pme_clr = 0, x_start = 0;
    logic busy, done, wake, rdy, irq, hwake, wv;
    logic [63:0] exp_q[$];
    logic [63:0] exp_word;
    int mismatches = 0, n_checks = 0, seed = 77840, cnt;
    pscw_if link();
    // released bus shows the inverse of the device word, not its last value
    assign link.ad_i = link.ad_dev_oe ? link.ad_dev_o : link.ad_host_oe ? link.ad_host_o : ~link.ad_dev_o;
    pscw_device u_pscw_device (.CLK_I(CLK_I), .EVENT_SET_I(ev_set), .EVENT_CLR_I(ev_clr),
        .EVENT_MASK_I(ev_mask), .POWER_CONTROL_I(pwr), .MAGIC_PACKET_I(magic), .PME_CLR_I(pme_clr),
        .XFER_START_I(x_start), .XFER_ADDR_I(x_addr), .XFER_DATA_I(x_data), .XFER_BUSY_O(busy),
        .XFER_DONE_O(done), .EVENT_FLAGS_O(flags), .WAKE_ACTIVE_O(wake), .LINK(link.device));
    pscw_host #(.RESET_HOLD_CYC(4)) u_pscw_host (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
        .ARB_ENABLE_I(arb), .LINK_READY_O(rdy), .IRQ_O(irq), .WAKE_O(hwake), .ADDR_O(h_addr),
        .DATA_O(h_data), .WORD_VALID_O(wv), .LINK(link.host));
    pscw_properties #(.RESET_HOLD_CYC(4)) u_props (.CLK_I(CLK_I), .rst_n(link.rst_n),
        .inta_n_o(link.inta_n_o), .inta_oe(link.inta_oe), .pme_n_o(link.pme_n_o),
        .pme_oe(link.pme_oe), .req_n(link.req_n), .gnt_n(link.gnt_n), .ad_dev_oe(link.ad_dev_oe));
    // logic has no rate dependence; the fast clock keeps runs short
    always #2 CLK_I = ~CLK_I;
    always @(posedge CLK_I)
    begin
        if (wv === 1'b1)
        begin
            exp_word = exp_q.pop_front();
            `CHK({h_addr, h_data}, exp_word)
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_ready;
        cnt = 0;
        while (rdy !== 1'b1 && cnt < 50)
        begin
            tick(1);
            cnt++;
        end
        `CHK(rdy, 1'b1)
    endtask
    // mode 1: second start while busy, mode 2: arbiter stalls
    task automatic xfer(input logic [31:0] a, input logic [31:0] d, input int mode);
        exp_q.push_back({a, d});
        arb <= (mode != 2);
        x_start <= 1'b1;
        x_addr <= a;
        x_data <= d;
        tick(1);
        x_start <= (mode == 1);
        x_addr <= ~a;
        tick(1);
        x_start <= 1'b0;
        if (mode == 2)
        begin
            tick(10);
            `CHK(busy, 1'b1)
            `CHK(link.req_n, 1'b0)
            `CHK(link.gnt_n, 1'b1)
            arb <= 1'b1;
        end
        cnt = 0;
        while (done !== 1'b1 && cnt < 60)
        begin
            tick(1);
            cnt++;
        end
        `CHK(done, 1'b1)
    endtask
    task automatic pulse_magic;
        magic <= 1'b1;
        tick(1);
        magic <= 1'b0;
    endtask
    initial
    begin
        #20000;
        mismatches++;
        final_report();
    end
    initial
    begin
        tick(2);
        RESET_N_I <= 1'b1;
        wait_ready();
        for (int i = 0; i < 4; i++)
            xfer($random(seed), $random(seed), i % 3);
        tick(4);
        `CHK(exp_q.size(), 0)
        ev_mask <= 8'hff;
        for (int i = 0; i < 8; i++)
        begin
            ev_set <= 8'h01 << i;
            tick(1);
            ev_set <= 8'h00;
            tick(3);
            `CHK(irq, 1'b1)
            `CHK(flags, 8'h01 << i)
            ev_clr <= 8'h01 << i;
            tick(1);
            ev_clr <= 8'h00;
            tick(3);
            `CHK(irq, 1'b0)
        end
        ev_mask <= 8'h00;
        ev_set <= 8'($random(seed)) | 8'h01;
        tick(1);
        ev_set <= 8'h00;
        tick(3);
        `CHK(irq, 1'b0)
        pulse_magic();
        tick(4);
        `CHK(wake, 1'b0)
        pwr <= (32'h1 << `PSCW_PWR_WAKE_EN_BIT) | (32'h1 << `PSCW_PWR_PROTO_SEL_BIT);
        pulse_magic();
        tick(12);
        `CHK(wake, 1'b1)
        `CHK(hwake, 1'b1)
        pme_clr <= 1'b1;
        tick(1);
        pme_clr <= 1'b0;
        tick(3);
        `CHK(wake, 1'b0)
        pwr <= 32'h1 << `PSCW_PWR_WAKE_EN_BIT;
        pulse_magic();
        cnt = 0;
        repeat (20)
        begin
            tick(1);
            if (wake === 1'b1)
                cnt++;
        end
        `CHK(cnt, `PSCW_PULSE_CYC)
        ev_mask <= 8'hff;
        ev_set <= 8'h80;
        tick(1);
        ev_set <= 8'h00;
        RESET_N_I <= 1'b0;
        tick(2);
        RESET_N_I <= 1'b1;
        tick(2);
        wait_ready();
        `CHK(flags, 8'h00)
        `CHK(busy, 1'b0)
        final_report();
    end
endmodule
